/* src/ssv_ctl_if.sv */
// Interface: reset status between sequencer and memory guard
interface ssv_ctl_if;
   logic rst_active;
   logic prog_busy;
   modport seq (output rst_active, input prog_busy);
   modport guard (input rst_active, output prog_busy);
endinterface

/* src/ssv_mem_guard.sv */
// Memory guard: blocks the embedded memory during reset and programming
module ssv_mem_guard (
   input wire logic clk,
   input wire logic rst,
   ssv_ctl_if.guard ctl,
   input wire logic bus_start,
   input wire logic write_stop,
   output logic bus_enable,
   output logic prog_start,
   output logic prog_busy,
   output logic txn_abort
);
   logic [ssv_pkg::CNT_W-1:0] prog_cnt_q;
   logic rst_act_q;

   // ----------------------------------------
   // Programming cycle
   // ----------------------------------------
   // A running cycle ignores reset; a new one cannot start in reset
   assign prog_start = write_stop && !ctl.rst_active && prog_cnt_q == '0;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         prog_cnt_q <= '0;
      end else if (prog_start) begin
         prog_cnt_q <= ssv_pkg::CNT_W'(ssv_pkg::PROG_CYC);
      end else if (prog_cnt_q != '0) begin
         prog_cnt_q <= prog_cnt_q - 1'b1;
      end
   end
   assign prog_busy = prog_cnt_q != '0;
   assign ctl.prog_busy = prog_busy;

   // ----------------------------------------
   // Bus gating
   // ----------------------------------------
   assign bus_enable = !ctl.rst_active && !prog_busy;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rst_act_q <= 1'b1;
      end else begin
         rst_act_q <= ctl.rst_active;
      end
   end
   // Abort pulse on reset entry; bus_enable refuses new starts
   assign txn_abort = ctl.rst_active && !rst_act_q;

   property p_no_prog_in_rst;
      @(posedge clk) disable iff (rst) ctl.rst_active && !prog_busy |=> !prog_busy;
   endproperty
   a_no_prog_in_rst: assert property (p_no_prog_in_rst)
      else $error("program cycle started during reset");

   property p_abort_on_entry;
      @(posedge clk) disable iff (rst) $rose(ctl.rst_active) |-> txn_abort;
   endproperty
   a_abort_on_entry: assert property (p_abort_on_entry)
      else $error("transaction not aborted on reset entry");

   property p_prog_len;
      @(posedge clk) disable iff (rst) prog_start |=> prog_busy [*8];
   endproperty
   a_prog_len: assert property (p_prog_len)
      else $error("programming cycle ended early");

   property p_prog_survives;
      @(posedge clk) disable iff (rst)
         prog_busy && ctl.rst_active && prog_cnt_q > ssv_pkg::CNT_W'(1) |=> prog_busy;
   endproperty
   a_prog_survives: assert property (p_prog_survives)
      else $error("programming aborted by reset");
   c_prog: cover property (@(posedge clk) disable iff (rst) prog_start);
endmodule

/* src/ssv_mr_filter.sv */
// Glitch filter and falling-edge detector for the manual reset pin
module ssv_push_filter #(
   parameter int LEN = 3
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic pin_i,
   output logic fall_o
);
   logic [ssv_pkg::FLT_W-1:0] cnt_q;
   logic stable_q;

   // Level must persist LEN cycles before it is believed
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cnt_q <= '0;
      end else if (pin_i == stable_q) begin
         cnt_q <= '0;
      end else if (cnt_q != ssv_pkg::FLT_W'(LEN)) begin
         cnt_q <= cnt_q + 1'b1;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         stable_q <= 1'b1;
      end else if (pin_i != stable_q && cnt_q == ssv_pkg::FLT_W'(LEN)) begin
         stable_q <= pin_i;
      end
   end

   assign fall_o = stable_q && !pin_i && cnt_q == ssv_pkg::FLT_W'(LEN);
endmodule

/* src/ssv_pkg.sv */
// Package: constants and types of the supply reset supervisor
package ssv_pkg;
   // ----------------------------------------
   // Clock and timing
   // ----------------------------------------
   localparam int CLK_HZ = 25_000_000;
   localparam int TIMEOUT_MS = 200;
   localparam int TIMEOUT_CYC = (CLK_HZ / 1000) * TIMEOUT_MS;
   localparam int GLITCH_NS = 100;
   // Least time: round up, at least one cycle
   localparam int GLITCH_CYC = (GLITCH_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
   localparam int PROG_MS = 5;
   // Longest time: round down
   localparam int PROG_CYC = (CLK_HZ / 1000) * PROG_MS;
   localparam int TICK_DIV = 25;
   localparam int CNT_W = 24;
   localparam int FLT_W = 4;

   // ----------------------------------------
   // Variants
   // ----------------------------------------
   localparam logic VARIANT_LOW = 1'b0;
   localparam logic VARIANT_HIGH = 1'b1;

   // ----------------------------------------
   // Sequencer states
   // ----------------------------------------
   typedef enum logic [1:0] {
      SSV_UNDER = 2'b00,
      SSV_TIMING = 2'b01,
      SSV_RUN = 2'b10
   } ssv_state_t;
endpackage

/* src/ssv_top.sv */
// Top: supply reset supervisor with manual reset and memory guard
module ssv_top #(
   parameter logic VARIANT = ssv_pkg::VARIANT_LOW,
   parameter int TIMEOUT_TICKS = ssv_pkg::TIMEOUT_CYC / ssv_pkg::TICK_DIV
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic supply_low,
   input wire logic reset_pin_i,
   output logic reset_pin_o,
   output logic reset_pin_oe,
   output logic reset_active,
   input wire logic bus_start,
   input wire logic write_stop,
   output logic bus_enable,
   output logic prog_start,
   output logic prog_busy,
   output logic txn_abort
);
   ssv_ctl_if ctl ();
   ssv_pkg::ssv_state_t state_q;
   logic [ssv_pkg::CNT_W-1:0] tmo_q;
   logic [4:0] div_q;
   logic tick;
   logic push_fall;
   logic push_pin;
   logic trigger;
   logic reload;

   // ----------------------------------------
   // Timebase
   // ----------------------------------------
   // Restarted with the count, so a timeout never loses part of a tick
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         div_q <= '0;
      end else if (reload || div_q == 5'(ssv_pkg::TICK_DIV - 1)) begin
         div_q <= '0;
      end else begin
         div_q <= div_q + 1'b1;
      end
   end
   assign tick = div_q == 5'(ssv_pkg::TICK_DIV - 1);

   // ----------------------------------------
   // Manual reset input
   // ----------------------------------------
   // Output-only variant has no input path
   assign push_pin = (VARIANT == ssv_pkg::VARIANT_LOW) ? reset_pin_i : 1'b1;
   ssv_push_filter #(.LEN(ssv_pkg::GLITCH_CYC)) u_filt (
      .clk(clk),
      .rst(rst),
      .pin_i(push_pin),
      .fall_o(push_fall)
   );
   // Own drive is not a trigger: only edges while released
   assign trigger = push_fall && state_q == ssv_pkg::SSV_RUN;
   assign reload = supply_low || trigger || state_q == ssv_pkg::SSV_UNDER;

   // ----------------------------------------
   // Sequencer
   // ----------------------------------------
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_q <= ssv_pkg::SSV_UNDER;
      end else begin
         case (state_q)
            ssv_pkg::SSV_UNDER: begin
               if (!supply_low) begin
                  state_q <= ssv_pkg::SSV_TIMING;
               end
            end
            ssv_pkg::SSV_TIMING: begin
               if (supply_low) begin
                  state_q <= ssv_pkg::SSV_UNDER;
               end else if (tick && tmo_q == 1) begin
                  state_q <= ssv_pkg::SSV_RUN;
               end
            end
            ssv_pkg::SSV_RUN: begin
               if (supply_low) begin
                  state_q <= ssv_pkg::SSV_UNDER;
               end else if (trigger) begin
                  state_q <= ssv_pkg::SSV_TIMING;
               end
            end
            default: state_q <= ssv_pkg::SSV_UNDER;
         endcase
      end
   end

   // Reload on every trigger, count down on timebase ticks
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         tmo_q <= '0;
      end else if (reload) begin
         tmo_q <= ssv_pkg::CNT_W'(TIMEOUT_TICKS);
      end else if (tick && tmo_q != '0) begin
         tmo_q <= tmo_q - 1'b1;
      end
   end

   // ----------------------------------------
   // Reset pin
   // ----------------------------------------
   assign reset_active = state_q != ssv_pkg::SSV_RUN;
   assign ctl.rst_active = reset_active;
   // Open drain: drive only the active level, release otherwise
   assign reset_pin_o = (VARIANT == ssv_pkg::VARIANT_LOW) ? 1'b0 : 1'b1;
   assign reset_pin_oe = reset_active;

   // ----------------------------------------
   // Memory guard
   // ----------------------------------------
   ssv_mem_guard u_guard (
      .clk(clk),
      .rst(rst),
      .ctl(ctl.guard),
      .bus_start(bus_start),
      .write_stop(write_stop),
      .bus_enable(bus_enable),
      .prog_start(prog_start),
      .prog_busy(prog_busy),
      .txn_abort(txn_abort)
   );

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   property p_low_asserts;
      @(posedge clk) disable iff (rst) supply_low |=> reset_active;
   endproperty
   a_low_asserts: assert property (p_low_asserts)
      else $error("reset not asserted on supply low");

   property p_release_needs_tmo;
      @(posedge clk) disable iff (rst)
         $fell(reset_active) |-> $past(tmo_q) == 1 && $past(tick);
   endproperty
   a_release_needs_tmo: assert property (p_release_needs_tmo)
      else $error("reset released before timeout");

   property p_trigger_holds;
      @(posedge clk) disable iff (rst)
         trigger && !supply_low |=> reset_active [*8];
   endproperty
   a_trigger_holds: assert property (p_trigger_holds)
      else $error("manual reset not held");

   property p_drive;
      @(posedge clk) disable iff (rst) reset_pin_oe == reset_active;
   endproperty
   a_drive: assert property (p_drive)
      else $error("pin drive mismatches reset state");

   property p_mem_off;
      @(posedge clk) disable iff (rst) reset_active |-> !bus_enable;
   endproperty
   a_mem_off: assert property (p_mem_off)
      else $error("memory enabled during reset");

   property p_reload;
      @(posedge clk) disable iff (rst)
         trigger |=> tmo_q == ssv_pkg::CNT_W'(TIMEOUT_TICKS);
   endproperty
   a_reload: assert property (p_reload)
      else $error("timeout not restarted");

   property p_edge;
      @(posedge clk) disable iff (rst)
         trigger && !supply_low |=> state_q == ssv_pkg::SSV_TIMING;
   endproperty
   a_edge: assert property (p_edge)
      else $error("manual edge did not start a timeout");

   property p_busy_off;
      @(posedge clk) disable iff (rst) ctl.prog_busy |-> !bus_enable;
   endproperty
   a_busy_off: assert property (p_busy_off)
      else $error("bus enabled while programming");

   c_release: cover property (@(posedge clk) disable iff (rst) $fell(reset_active));
   c_manual: cover property (@(posedge clk) disable iff (rst) trigger);
   c_brown: cover property (@(posedge clk) disable iff (rst)
      state_q == ssv_pkg::SSV_RUN ##1 supply_low);
endmodule

/* verification/ssv_host_model.sv */
// Host side model: reset pin wire with pull resistor and host access gate
module ssv_host_model #(
   parameter logic PULL = 1'b1
) (
   input wire logic reset_pin_o,
   input wire logic reset_pin_oe,
   input wire logic push_n,
   output logic pin_level,
   output logic may_access
);
   timeunit 1ns;
   timeprecision 1ps;
   // ----------------------------------------
   // Wire level
   // ----------------------------------------
   // Open drain: released pin falls back to the pull level
   assign pin_level = (reset_pin_oe ? reset_pin_o : PULL) & push_n;
   // Host touches memory only once reset has been released
   assign may_access = (pin_level === PULL);
endmodule

/* verification/supply_reset_supervisor_tb.sv */
// Testbench of the supply reset supervisor
module supply_reset_supervisor_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int TICKS = 4;
   localparam int TMO = TICKS * 25;
   logic clk, rst, supply_low, push_n, bus_start, write_stop;
   logic pin_o, pin_oe, reset_active, pin_level, may_access;
   logic bus_enable, prog_start, prog_busy, txn_abort, ab, ps;
   logic hi_o, hi_oe, hi_active, hi_level;
   int num_errors = 0;
   int tests_run = 0;
   int cyc = 0;
   int n;

   ssv_top #(.VARIANT(ssv_pkg::VARIANT_LOW), .TIMEOUT_TICKS(TICKS)) u_ssv_top (
      .clk(clk), .rst(rst), .supply_low(supply_low), .reset_pin_i(pin_level),
      .reset_pin_o(pin_o), .reset_pin_oe(pin_oe), .reset_active(reset_active),
      .bus_start(bus_start), .write_stop(write_stop), .bus_enable(bus_enable),
      .prog_start(prog_start), .prog_busy(prog_busy), .txn_abort(txn_abort));
   ssv_host_model #(.PULL(1'b1)) u_ssv_host_model (
      .reset_pin_o(pin_o), .reset_pin_oe(pin_oe), .push_n(push_n),
      .pin_level(pin_level), .may_access(may_access));
   // Output-only variant sees the pushed pin and must ignore it
   ssv_top #(.VARIANT(ssv_pkg::VARIANT_HIGH), .TIMEOUT_TICKS(TICKS)) u_ssv_top_hi (
      .clk(clk), .rst(rst), .supply_low(supply_low), .reset_pin_i(pin_level),
      .reset_pin_o(hi_o), .reset_pin_oe(hi_oe), .reset_active(hi_active),
      .bus_start(bus_start), .write_stop(write_stop), .bus_enable(),
      .prog_start(), .prog_busy(), .txn_abort());
   ssv_host_model #(.PULL(1'b0)) u_ssv_host_model_hi (
      .reset_pin_o(hi_o), .reset_pin_oe(hi_oe), .push_n(1'b1),
      .pin_level(hi_level), .may_access());

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         num_errors++;
         $display("ERROR %s expected %0h seen %0h", name, exp, seen);
      end
   endtask

   task automatic results;
      if (num_errors == 0 && tests_run > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   // Pulses stand one cycle, so gather them over a window
   task automatic watch(input int k);
      ab = 1'b0;
      ps = 1'b0;
      repeat (k) begin
         @(negedge clk);
         ab = ab | (txn_abort === 1'b1);
         ps = ps | (prog_start === 1'b1);
      end
   endtask

   task automatic wait_release;
      n = 0;
      while (reset_active !== 1'b0 && n < 400) begin
         @(negedge clk);
         n++;
      end
   endtask

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_power_up;
      repeat (10) @(negedge clk);
      check("low_hold", reset_active, 1'b1);
      check("low_pin", pin_level, 1'b0);
      check("hi_pin", hi_level, 1'b1);
      supply_low = 1'b0;
      wait_release();
      // Full timeout counted from the first edge with the supply good
      check("tmo_len", n, TMO + 1);
      check("rel_oe", pin_oe, 1'b0);
      check("rel_pin", pin_level, 1'b1);
      check("rel_hi_pin", hi_level, 1'b0);
      check("rel_bus", bus_enable, 1'b1);
   endtask

   task automatic t_brownout;
      supply_low = 1'b1;
      watch(3);
      check("bo_rst", reset_active, 1'b1);
      check("bo_hi_rst", hi_active, 1'b1);
      check("bo_abort", ab, 1'b1);
      check("bo_bus", bus_enable, 1'b0);
      // Idle memory, but in reset: a write stop must not start programming
      write_stop = 1'b1;
      bus_start = 1'b1;
      #1;
      check("bo_nostart", prog_start, 1'b0);
      check("bo_refuse", bus_enable, 1'b0);
      @(negedge clk);
      write_stop = 1'b0;
      bus_start = 1'b0;
      check("bo_idle", prog_busy, 1'b0);
      repeat (19) @(negedge clk);
      supply_low = 1'b0;
      wait_release();
      check("bo_len", n, TMO + 1);
   endtask

   task automatic t_manual;
      // Let the pin filter settle on the released level first
      repeat (6) @(negedge clk);
      push_n = 1'b0;
      repeat (2) @(negedge clk);
      push_n = 1'b1;
      repeat (5) @(negedge clk);
      check("glitch", reset_active, 1'b0);
      push_n = 1'b0;
      repeat (5) @(negedge clk);
      push_n = 1'b1;
      @(negedge clk);
      check("man_rst", reset_active, 1'b1);
      check("man_drive", pin_level, 1'b0);
      check("man_hi_ignored", hi_active, 1'b0);
      wait_release();
      // Trigger edge lies two cycles before the wait starts
      check("man_len", n, TMO - 2);
   endtask

   task automatic t_held;
      repeat (6) @(negedge clk);
      push_n = 1'b0;
      repeat (5) @(negedge clk);
      check("held_rst", reset_active, 1'b1);
      wait_release();
      check("held_len", n, TMO - 1);
      // Pin still held low: a level must not trigger again
      repeat (20) @(negedge clk);
      check("held_level", reset_active, 1'b0);
      push_n = 1'b1;
      repeat (6) @(negedge clk);
   endtask

   task automatic t_write;
      check("host_ok", may_access, 1'b1);
      write_stop = 1'b1;
      #1;
      check("ws_start", prog_start, 1'b1);
      @(negedge clk);
      write_stop = 1'b0;
      watch(2);
      check("ws_busy", prog_busy, 1'b1);
      check("ws_bus", bus_enable, 1'b0);
      supply_low = 1'b1;
      watch(3);
      write_stop = 1'b1;
      bus_start = 1'b1;
      @(negedge clk);
      write_stop = 1'b0;
      bus_start = 1'b0;
      watch(5);
      check("rs_nostart", ps, 1'b0);
      check("rs_busy", prog_busy, 1'b1);
      check("rs_bus", bus_enable, 1'b0);
   endtask

   // ----------------------------------------
   // Clock, timeout and sequence
   // ----------------------------------------
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         num_errors++;
         results();
      end
   end

   initial begin
      rst = 1'b1;
      supply_low = 1'b1;
      push_n = 1'b1;
      bus_start = 1'b0;
      write_stop = 1'b0;
      repeat (6) @(negedge clk);
      rst = 1'b0;
      t_power_up();
      t_brownout();
      t_manual();
      t_held();
      t_write();
      results();
   end
endmodule
